/* File: trc_defs.vh */
// Shared constants for the transmit rate divider and receiver offset calibration block.
// Assumes the includer sits on the single controller clock with a synchronous reset.
`ifndef TRC_DEFS_VH
`define TRC_DEFS_VH
// Divider select and readback codes.
`define TRC_CODE_DIV1 2'h0
`define TRC_CODE_DIV2 2'h1
`define TRC_CODE_DIV4 2'h2
`define TRC_CODE_BAD 2'h3
// Raw divide ratios carried on the lane bus.
`define TRC_RATIO_DIV1 8'h01
`define TRC_RATIO_DIV2 8'h02
`define TRC_RATIO_DIV4 8'h04
// Lane bus operations.
`define TRC_OP_W 3
`define TRC_DATA_W 8
`define TRC_OP_TXDIV_WR 3'h0
`define TRC_OP_TXDIV_RD 3'h1
`define TRC_OP_RX_ISOLATE 3'h2
`define TRC_OP_CDR_DIV_RD 3'h3
`define TRC_OP_CDR_DIV_WR 3'h4
`define TRC_OP_CAL_BUF 3'h5
`define TRC_OP_CAL_CDR 3'h6
`define TRC_OP_RX_CONNECT 3'h7
// Fixed recovery divider set used while calibrating.
`define TRC_CAL_CDR_DIV 8'h11
// Bit of a calibration answer that reports a pass.
`define TRC_CAL_PASS_BIT 0
`endif

/* File: trc_lane_cmd.v */
// One outstanding command on the controller-to-lane bus, answered by the lane-to-controller bus.
// Assumes the addressed lane answers every command with one response strobe.
`timescale 1ns/100ps
`default_nettype none
`include "trc_defs.vh"
module trc_lane_cmd #(
   parameter LANE_AW = 2
) (
   // Clock and reset
   input wire core_clk,
   input wire srst,
   // Request from the sequencer
   input wire start,
   input wire [LANE_AW-1:0] lane,
   input wire [`TRC_OP_W-1:0] op,
   input wire [`TRC_DATA_W-1:0] wdata,
   output reg done,
   output reg [`TRC_DATA_W-1:0] rdData,
   // Lane buses
   output reg cmdValid,
   output reg [LANE_AW-1:0] cmdLane,
   output reg [`TRC_OP_W-1:0] cmdOp,
   output reg [`TRC_DATA_W-1:0] cmdData,
   input wire rspValid,
   input wire [`TRC_DATA_W-1:0] rspData
);
   always @(posedge core_clk)
   begin
      if (srst)
      begin
         cmdValid <= 1'b0;
         cmdLane <= {LANE_AW{1'b0}};
         cmdOp <= 3'h0;
         cmdData <= 8'h00;
         done <= 1'b0;
         rdData <= 8'h00;
      end
      else
      begin
         done <= 1'b0;
         if (start && !cmdValid)
         begin
            cmdValid <= 1'b1;
            cmdLane <= lane;
            cmdOp <= op;
            cmdData <= wdata;
         end
         else if (cmdValid && rspValid)
         begin
            cmdValid <= 1'b0;
            done <= 1'b1;
            rdData <= rspData;
         end
      end
   end
endmodule
`default_nettype wire

/* File: trc_lane_walker.v */
// Walks the lane indices in order, stopping only on lanes that own a receiver.
// Assumes one advance request per offered lane.
`timescale 1ns/100ps
`default_nettype none
module trc_lane_walker #(
   parameter NUM_LANES = 4,
   parameter LANE_AW = 2,
   parameter [NUM_LANES-1:0] RX_LANE_MASK = {NUM_LANES{1'b1}}
) (
   // Clock and reset
   input wire core_clk,
   input wire srst,
   // Control
   input wire first,
   input wire next,
   output wire laneValid,
   output wire [LANE_AW-1:0] lane,
   output reg finished
);
   reg [LANE_AW-1:0] idx_q;
   reg run_q;
   wire [31:0] idxWide;
   wire isLast;
   wire hasRx;
   assign idxWide = {{(32-LANE_AW){1'b0}}, idx_q};
   assign isLast = (idxWide == NUM_LANES - 1);
   assign hasRx = RX_LANE_MASK[idx_q];
   assign laneValid = run_q && hasRx;
   assign lane = idx_q;
   always @(posedge core_clk)
   begin
      if (srst)
      begin
         idx_q <= {LANE_AW{1'b0}};
         run_q <= 1'b0;
         finished <= 1'b0;
      end
      else
      begin
         finished <= 1'b0;
         if (first)
         begin
            idx_q <= {LANE_AW{1'b0}};
            run_q <= 1'b1;
         end
         else if (run_q && (!hasRx || next))
         begin
            if (isLast)
            begin
               run_q <= 1'b0;
               finished <= 1'b1;
            end
            else
            begin
               idx_q <= idx_q + 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: trc_tx_rate_rx_cal.v */
// Top of the transmit rate divider control and power-up receiver offset calibration.
// Assumes user logic and lanes share core_clk, so no input is synchronised.
// Assumes srst is the power-on reset of the controller.
`timescale 1ns/100ps
`default_nettype none
`include "trc_defs.vh"
module trc_tx_rate_rx_cal #(
   parameter NUM_LANES = 4,
   parameter LANE_AW = 2,
   parameter [NUM_LANES-1:0] RX_LANE_MASK = {NUM_LANES{1'b1}}
) (
   // Clock and reset
   input wire core_clk,
   input wire srst,
   // User control
   input wire [LANE_AW-1:0] laneAddr,
   input wire [1:0] rateSel,
   input wire rateWrReq,
   input wire rateRdReq,
   output reg busy,
   output reg [1:0] rateOut,
   output reg rateOutValid,
   output reg rateSelErr,
   output reg calDone,
   // Controller-to-lane bus
   output wire toLaneValid,
   output wire [LANE_AW-1:0] toLaneAddr,
   output wire [`TRC_OP_W-1:0] toLaneOp,
   output wire [`TRC_DATA_W-1:0] toLaneData,
   // Lane-to-controller bus
   input wire fromLaneValid,
   input wire [`TRC_DATA_W-1:0] fromLaneData
);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // States and functions.
   // Power-up calibration walk, one receiver lane at a time.
   localparam [3:0] S_POR = 4'h0;
   localparam [3:0] S_SEEK = 4'h1;
   localparam [3:0] S_SAVE = 4'h2;
   localparam [3:0] S_ISO = 4'h3;
   localparam [3:0] S_FORCE = 4'h4;
   localparam [3:0] S_BUF = 4'h5;
   localparam [3:0] S_CDR = 4'h6;
   localparam [3:0] S_RESTORE = 4'h7;
   localparam [3:0] S_RECON = 4'h8;

   // Idle and user divider access.
   localparam [3:0] S_IDLE = 4'h9;
   localparam [3:0] S_RATE_WR = 4'ha;
   localparam [3:0] S_RATE_RD = 4'hb;

   // Maps a select code to the ratio the lane divider takes.
   function [`TRC_DATA_W-1:0] codeToRatio;
      input [1:0] code;
      begin
         case (code)
            `TRC_CODE_DIV1: codeToRatio = `TRC_RATIO_DIV1;
            `TRC_CODE_DIV2: codeToRatio = `TRC_RATIO_DIV2;
            `TRC_CODE_DIV4: codeToRatio = `TRC_RATIO_DIV4;
            default: codeToRatio = `TRC_RATIO_DIV1;
         endcase
      end
   endfunction

   // Inverse mapping, so both directions share one encoding.
   function [1:0] ratioToCode;
      input [`TRC_DATA_W-1:0] ratio;
      begin
         case (ratio)
            `TRC_RATIO_DIV1: ratioToCode = `TRC_CODE_DIV1;
            `TRC_RATIO_DIV2: ratioToCode = `TRC_CODE_DIV2;
            `TRC_RATIO_DIV4: ratioToCode = `TRC_CODE_DIV4;
            default: ratioToCode = `TRC_CODE_BAD;
         endcase
      end
   endfunction

   // True for the states that step through one lane's calibration.
   function isCalStep;
      input [3:0] st;
      begin
         case (st)
            S_SAVE, S_ISO, S_FORCE, S_BUF, S_CDR, S_RESTORE, S_RECON: isCalStep = 1'b1;
            default: isCalStep = 1'b0;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Registers.
   reg [3:0] state_q;
   reg [3:0] state_d;
   reg pend_q;
   reg pend_d;
   reg [`TRC_DATA_W-1:0] cdrSave_q;
   reg [`TRC_DATA_W-1:0] cdrSave_d;
   reg [LANE_AW-1:0] laneCap_q;
   reg [LANE_AW-1:0] laneCap_d;
   reg [1:0] selCap_q;
   reg [1:0] selCap_d;
   reg [1:0] rateOut_d;
   reg rateOutValid_d;
   reg rateSelErr_d;
   reg calDone_d;

   // Handshakes with the command port and the lane walker.
   reg cmdStart;
   reg [`TRC_OP_W-1:0] cmdOp;
   reg [`TRC_DATA_W-1:0] cmdData;
   reg walkFirst;
   reg walkNext;
   wire [LANE_AW-1:0] cmdLane;
   wire cmdDone;
   wire [`TRC_DATA_W-1:0] cmdRdData;
   wire walkLaneValid;
   wire [LANE_AW-1:0] walkLane;
   wire walkFinished;
   wire calPass;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Lane walker and command port.
   trc_lane_walker #(
      .NUM_LANES(NUM_LANES),
      .LANE_AW(LANE_AW),
      .RX_LANE_MASK(RX_LANE_MASK)
   ) uWalker (
      .core_clk(core_clk),
      .srst(srst),
      .first(walkFirst),
      .next(walkNext),
      .laneValid(walkLaneValid),
      .lane(walkLane),
      .finished(walkFinished)
   );

   // The walker lane drives calibration traffic, so the user address cannot steer it.
   assign cmdLane = isCalStep(state_q) ? walkLane : laneCap_q;

   trc_lane_cmd #(
      .LANE_AW(LANE_AW)
   ) uCmd (
      .core_clk(core_clk),
      .srst(srst),
      .start(cmdStart),
      .lane(cmdLane),
      .op(cmdOp),
      .wdata(cmdData),
      .done(cmdDone),
      .rdData(cmdRdData),
      .cmdValid(toLaneValid),
      .cmdLane(toLaneAddr),
      .cmdOp(toLaneOp),
      .cmdData(toLaneData),
      .rspValid(fromLaneValid),
      .rspData(fromLaneData)
   );

   assign calPass = cmdRdData[`TRC_CAL_PASS_BIT];

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Operation carried by each state.
   always @*
   begin
      cmdOp = `TRC_OP_TXDIV_RD;
      cmdData = 8'h00;
      case (state_q)
         S_SAVE: cmdOp = `TRC_OP_CDR_DIV_RD;
         S_ISO: cmdOp = `TRC_OP_RX_ISOLATE;
         S_FORCE:
         begin
            cmdOp = `TRC_OP_CDR_DIV_WR;
            cmdData = `TRC_CAL_CDR_DIV;
         end
         S_BUF: cmdOp = `TRC_OP_CAL_BUF;
         S_CDR: cmdOp = `TRC_OP_CAL_CDR;
         S_RESTORE:
         begin
            cmdOp = `TRC_OP_CDR_DIV_WR;
            cmdData = cdrSave_q;
         end
         S_RECON: cmdOp = `TRC_OP_RX_CONNECT;
         S_RATE_WR:
         begin
            // Only the transmit divider is named; no receive divider is written.
            cmdOp = `TRC_OP_TXDIV_WR;
            cmdData = codeToRatio(selCap_q);
         end
         S_RATE_RD: cmdOp = `TRC_OP_TXDIV_RD;
         default: cmdOp = `TRC_OP_TXDIV_RD;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Sequencer.
   // A lane that never passes keeps busy high; there is no give-up count.
   always @*
   begin
      state_d = state_q;
      pend_d = pend_q;
      cdrSave_d = cdrSave_q;
      laneCap_d = laneCap_q;
      selCap_d = selCap_q;
      rateOut_d = rateOut;
      rateOutValid_d = 1'b0;
      rateSelErr_d = 1'b0;
      calDone_d = calDone;
      cmdStart = 1'b0;
      walkFirst = 1'b0;
      walkNext = 1'b0;
      case (state_q)
         S_POR:
         begin
            // Starts on its own after reset; no request is awaited.
            walkFirst = 1'b1;
            state_d = S_SEEK;
         end
         S_SEEK:
         begin
            // The walker steps over a lane without a receiver on its own.
            if (walkLaneValid)
            begin
               state_d = S_SAVE;
            end
            else if (walkFinished)
            begin
               state_d = S_IDLE;
               calDone_d = 1'b1;
            end
         end
         S_SAVE, S_ISO, S_FORCE, S_BUF, S_CDR, S_RESTORE, S_RECON,
         S_RATE_WR, S_RATE_RD:
         begin
            if (!pend_q)
            begin
               cmdStart = 1'b1;
               pend_d = 1'b1;
            end
            else if (cmdDone)
            begin
               pend_d = 1'b0;
               case (state_q)
                  S_SAVE:
                  begin
                     cdrSave_d = cmdRdData;
                     state_d = S_ISO;
                  end
                  S_ISO: state_d = S_FORCE;
                  S_FORCE: state_d = S_BUF;
                  S_BUF:
                  begin
                     // A failed step is issued again, so busy never falls on a failure.
                     if (calPass)
                     begin
                        state_d = S_CDR;
                     end
                  end
                  S_CDR:
                  begin
                     if (calPass)
                     begin
                        state_d = S_RESTORE;
                     end
                  end
                  S_RESTORE: state_d = S_RECON;
                  S_RECON:
                  begin
                     walkNext = 1'b1;
                     state_d = S_SEEK;
                  end
                  S_RATE_WR: state_d = S_IDLE;
                  S_RATE_RD:
                  begin
                     rateOut_d = ratioToCode(cmdRdData);
                     rateOutValid_d = 1'b1;
                     state_d = S_IDLE;
                  end
                  default: state_d = S_IDLE;
               endcase
            end
         end
         S_IDLE:
         begin
            // Requests are taken only here, so anything raised while busy is dropped.
            if (rateWrReq)
            begin
               if (rateSel == `TRC_CODE_BAD)
               begin
                  rateSelErr_d = 1'b1;
               end
               else
               begin
                  laneCap_d = laneAddr;
                  selCap_d = rateSel;
                  state_d = S_RATE_WR;
               end
            end
            else if (rateRdReq)
            begin
               laneCap_d = laneAddr;
               state_d = S_RATE_RD;
            end
         end
         default: state_d = S_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // State registers.
   // Pulses last one cycle; levels hold until the sequencer moves them.
   always @(posedge core_clk)
   begin
      if (srst)
      begin
         state_q <= S_POR;
         pend_q <= 1'b0;
         cdrSave_q <= 8'h00;
         laneCap_q <= {LANE_AW{1'b0}};
         selCap_q <= `TRC_CODE_DIV1;
         busy <= 1'b0;
         rateOut <= `TRC_CODE_DIV1;
         rateOutValid <= 1'b0;
         rateSelErr <= 1'b0;
         calDone <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         pend_q <= pend_d;
         cdrSave_q <= cdrSave_d;
         laneCap_q <= laneCap_d;
         selCap_q <= selCap_d;
         // Busy follows the next state, so it rises one cycle after reset release.
         busy <= (state_d != S_IDLE);
         rateOut <= rateOut_d;
         rateOutValid <= rateOutValid_d;
         rateSelErr <= rateSelErr_d;
         // Only reset clears this, so calibration never repeats while powered.
         calDone <= calDone_d;
      end
   end

endmodule
`default_nettype wire

/* File: trc_tx_rate_rx_cal_chk.sv */
// Port assertions for the transmit rate divider and receiver calibration top.
// Assumes one clock, core_clk, and srst as the synchronous power-on reset.
`timescale 1ns/100ps
`default_nettype none
`include "trc_defs.vh"
module trc_tx_rate_rx_cal_chk #(
   parameter NUM_LANES = 4,
   parameter LANE_AW = 2
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // User side
   input wire logic [LANE_AW-1:0] laneAddr,
   input wire logic [1:0] rateSel,
   input wire logic rateWrReq,
   input wire logic rateRdReq,
   input wire logic busy,
   input wire logic [1:0] rateOut,
   input wire logic rateOutValid,
   input wire logic rateSelErr,
   input wire logic calDone,
   // Lane buses
   input wire logic toLaneValid,
   input wire logic [LANE_AW-1:0] toLaneAddr,
   input wire logic [`TRC_OP_W-1:0] toLaneOp,
   input wire logic [`TRC_DATA_W-1:0] toLaneData,
   input wire logic fromLaneValid,
   input wire logic [`TRC_DATA_W-1:0] fromLaneData
);
   wire idle = calDone && !busy;
   logic [1:0] rdCode_q;
   ////////////////////////////////////////////////////////////////////////////////
   // Code the lane answered with, kept so a slow readback can be matched later.
   always @(posedge core_clk)
   begin
      if (toLaneValid && fromLaneValid)
         rdCode_q <= (fromLaneData == 8'h01) ? 2'h0 : (fromLaneData == 8'h02) ? 2'h1 :
            (fromLaneData == 8'h04) ? 2'h2 : 2'h3;
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking dcb @(posedge core_clk);
   endclocking
   default disable iff (srst);
   AST_BUSY_LOW: assert property (disable iff (1'b0) srst |=> !busy)
      else $error("busy high in the first cycle after reset");
   AST_BUSY_RISE: assert property (disable iff (1'b0) srst ##1 !srst |=> busy)
      else $error("busy not raised in the second cycle");
   AST_CMD_HOLD: assert property (toLaneValid && !fromLaneValid |=> toLaneValid &&
      $stable({toLaneAddr, toLaneOp, toLaneData})) else $error("lane command moved");
   AST_CMD_DROP: assert property (toLaneValid && fromLaneValid |=> !toLaneValid)
      else $error("lane command kept after its answer");
   AST_IDLE_QUIET: assert property (!busy |-> !toLaneValid)
      else $error("lane command while not busy");
   AST_WR_CMD: assert property (idle && rateWrReq && rateSel != 2'h3 |=> busy ##1
      (toLaneValid && toLaneOp == `TRC_OP_TXDIV_WR && toLaneAddr == $past(laneAddr, 2)
      && toLaneData == (8'h01 << $past(rateSel, 2)))) else $error("bad divider write");
   AST_RD_CMD: assert property (idle && rateRdReq && !rateWrReq |=> busy ##1
      (toLaneValid && toLaneOp == `TRC_OP_TXDIV_RD && toLaneAddr == $past(laneAddr, 2)))
      else $error("bad divider read command");
   AST_SEL_ERR: assert property (idle && rateWrReq && rateSel == 2'h3 |=>
      rateSelErr && !busy) else $error("illegal select not refused");
   AST_RD_CODE: assert property (toLaneValid && fromLaneValid &&
      toLaneOp == `TRC_OP_TXDIV_RD |-> ##[1:3] rateOutValid && rateOut == rdCode_q)
      else $error("readback code wrong");
   AST_CAL_END: assert property ($rose(calDone) |-> $fell(busy))
      else $error("calibration end without busy fall");
   AST_CAL_ONCE: assert property (calDone |=> calDone)
      else $error("calibration restarted");
   AST_TX_ONLY: assert property (calDone && toLaneValid |->
      toLaneOp == `TRC_OP_TXDIV_WR || toLaneOp == `TRC_OP_TXDIV_RD)
      else $error("receive side touched by a rate access");
   cover property (rateSelErr);
   cover property (rateOutValid && rateOut == 2'h1);
   cover property (fromLaneValid && toLaneOp == `TRC_OP_CAL_BUF && !fromLaneData[0]);
   cover property ($rose(calDone));
endmodule
bind trc_tx_rate_rx_cal trc_tx_rate_rx_cal_chk #(.NUM_LANES(NUM_LANES), .LANE_AW(LANE_AW))
   trc_tx_rate_rx_cal_chk_inst (.core_clk(core_clk), .srst(srst), .laneAddr(laneAddr),
   .rateSel(rateSel), .rateWrReq(rateWrReq), .rateRdReq(rateRdReq), .busy(busy),
   .rateOut(rateOut), .rateOutValid(rateOutValid), .rateSelErr(rateSelErr),
   .calDone(calDone), .toLaneValid(toLaneValid), .toLaneAddr(toLaneAddr),
   .toLaneOp(toLaneOp), .toLaneData(toLaneData), .fromLaneValid(fromLaneValid),
   .fromLaneData(fromLaneData));
`default_nettype wire

/* File: trc_lane_model.sv */
// Behavioural model of four transceiver lanes on the lane buses.
// Assumes one command outstanding at a time; lane state survives srst.
`timescale 1ns/100ps
`default_nettype none
`include "trc_defs.vh"
module trc_lane_model (
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Test control
   input wire logic [2:0] rspDelay,
   input wire logic [1:0] failCount,
   output logic seqErr,
   output logic [3:0] calLanes,
   // Lane buses
   input wire logic toLaneValid,
   input wire logic [1:0] toLaneAddr,
   input wire logic [2:0] toLaneOp,
   input wire logic [7:0] toLaneData,
   output logic fromLaneValid,
   output logic [7:0] fromLaneData
);
   logic [7:0] txRatio [0:3];
   logic [7:0] cdrDiv [0:3];
   logic [3:0] iso;
   logic [2:0] cnt;
   logic [1:0] failLeft;
   logic answered;
   wire stepOk = iso[toLaneAddr] && cdrDiv[toLaneAddr] == `TRC_CAL_CDR_DIV;
   wire [7:0] cdrHome = 8'h30 + {6'h00, toLaneAddr};
   initial
   begin
      for (int l = 0; l < 4; l++)
      begin
         txRatio[l] = 8'h01;
         cdrDiv[l] = 8'h30 + l[7:0];
      end
      iso = 4'h0;
      fromLaneValid = 1'b0;
      fromLaneData = 8'h5a;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // One answer per command; the data bus toggles when idle so stale data never looks valid.
   always @(posedge core_clk)
   begin
      fromLaneValid <= 1'b0;
      fromLaneData <= ~fromLaneData;
      if (srst)
      begin
         answered <= 1'b0;
         cnt <= 3'h0;
         failLeft <= failCount;
         seqErr <= 1'b0;
         calLanes <= 4'h0;
      end
      else if (!toLaneValid)
      begin
         answered <= 1'b0;
         cnt <= 3'h0;
      end
      else if (!answered && cnt != rspDelay)
         cnt <= cnt + 3'h1;
      else if (!answered)
      begin
         answered <= 1'b1;
         fromLaneValid <= 1'b1;
         fromLaneData <= 8'h00;
         case (toLaneOp)
            `TRC_OP_TXDIV_WR: txRatio[toLaneAddr] <= toLaneData;
            `TRC_OP_TXDIV_RD: fromLaneData <= txRatio[toLaneAddr];
            `TRC_OP_RX_ISOLATE: iso[toLaneAddr] <= 1'b1;
            `TRC_OP_CDR_DIV_RD: fromLaneData <= cdrDiv[toLaneAddr];
            `TRC_OP_CDR_DIV_WR: cdrDiv[toLaneAddr] <= toLaneData;
            `TRC_OP_CAL_BUF, `TRC_OP_CAL_CDR:
            begin
               seqErr <= seqErr | !stepOk;
               fromLaneData <= {7'h00, failLeft == 2'h0};
               if (failLeft != 2'h0)
                  failLeft <= failLeft - 2'h1;
               else if (toLaneOp == `TRC_OP_CAL_CDR)
                  calLanes[toLaneAddr] <= 1'b1;
            end
            default:
            begin
               seqErr <= seqErr | (cdrDiv[toLaneAddr] != cdrHome);
               iso[toLaneAddr] <= 1'b0;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: trc_tx_rate_rx_cal_test.sv */
// Self-checking bench for the rate divider and calibration top.
// Assumes the lane model answers on the lane buses with a random delay.
`timescale 1ns/100ps
`default_nettype none
`include "trc_defs.vh"
module trc_tx_rate_rx_cal_test;
   localparam logic [3:0] RX_MASK = 4'b1011;
   logic core_clk = 1'b0;
   logic srst, rateWrReq, rateRdReq, busy, rateOutValid, rateSelErr, calDone;
   logic [1:0] laneAddr, rateSel, rateOut, toLaneAddr, failCount;
   logic toLaneValid, fromLaneValid, seqErr;
   logic [2:0] toLaneOp, rspDelay;
   logic [7:0] toLaneData, fromLaneData;
   logic [3:0] calLanes;
   integer seed = 95;
   int n_mismatch = 0;
   int compares = 0;
   always #5 core_clk = ~core_clk;
   trc_tx_rate_rx_cal #(.NUM_LANES(4), .LANE_AW(2), .RX_LANE_MASK(RX_MASK))
      trc_tx_rate_rx_cal_inst (.core_clk(core_clk), .srst(srst), .laneAddr(laneAddr),
      .rateSel(rateSel), .rateWrReq(rateWrReq), .rateRdReq(rateRdReq), .busy(busy),
      .rateOut(rateOut), .rateOutValid(rateOutValid), .rateSelErr(rateSelErr),
      .calDone(calDone), .toLaneValid(toLaneValid), .toLaneAddr(toLaneAddr),
      .toLaneOp(toLaneOp), .toLaneData(toLaneData), .fromLaneValid(fromLaneValid),
      .fromLaneData(fromLaneData));
   trc_lane_model trc_lane_model_inst (.core_clk(core_clk), .srst(srst),
      .rspDelay(rspDelay), .failCount(failCount), .seqErr(seqErr), .calLanes(calLanes),
      .toLaneValid(toLaneValid), .toLaneAddr(toLaneAddr), .toLaneOp(toLaneOp),
      .toLaneData(toLaneData), .fromLaneValid(fromLaneValid), .fromLaneData(fromLaneData));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic flag(input string msg);
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, msg);
   endtask
   task automatic cmpFlag(input logic got, input logic exp);
      compares++;
      if (got !== exp) flag("flag mismatch");
   endtask
   task automatic cmpCode(input logic [1:0] got, input logic [1:0] exp);
      compares++;
      if (got !== exp) flag("code mismatch");
   endtask
   task automatic cmpByte(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) flag("byte mismatch");
   endtask
   task end_of_test;
      $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Divide ratio the lane should hold after a write of this code.
   function automatic logic [7:0] ratioOf(input logic [1:0] code);
      return (code == 2'h0) ? 8'h01 : (code == 2'h1) ? 8'h02 : 8'h04;
   endfunction
   // One user access; reads aimed at the busy controller must be ignored.
   task automatic access(input logic wr, input logic [1:0] lane, input logic [1:0] code,
      output logic [1:0] got, output logic err);
      int i;
      // An idle edge first, so no strobe is driven twice in one time step.
      @(negedge core_clk);
      laneAddr = lane;
      rateSel = code;
      rateWrReq = wr;
      rateRdReq = !wr;
      got = 2'h3;
      err = 1'b0;
      @(negedge core_clk);
      rateWrReq = 1'b0;
      for (i = 0; i < 100 && busy !== 1'b0; i++)
      begin
         rateRdReq = ($random(seed) & 1) != 0;
         @(negedge core_clk);
      end
      rateRdReq = 1'b0;
      if (rateOutValid === 1'b1) got = rateOut;
      if (rateSelErr === 1'b1) err = 1'b1;
      if (busy !== 1'b0)
      begin
         flag("access hung");
         end_of_test;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      int i;
      logic [1:0] lane, code, got;
      logic err;
      logic [1:0] expCode [0:3];
      expCode = '{2'h0, 2'h0, 2'h0, 2'h0};
      laneAddr = 2'h0;
      rateSel = 2'h0;
      rateWrReq = 1'b0;
      rateRdReq = 1'b0;
      srst = 1'b1;
      rspDelay = 3'h0;
      failCount = 2'h2;
      repeat (4) @(negedge core_clk);
      srst = 1'b0;
      cmpFlag(busy, 1'b0);
      @(negedge core_clk);
      cmpFlag(busy, 1'b1);
      for (i = 0; i < 3000 && busy !== 1'b0; i++)
      begin
         laneAddr = 2'($random(seed));
         rspDelay = 3'($random(seed));
         @(negedge core_clk);
      end
      cmpFlag(busy, 1'b0);
      cmpFlag(calDone, 1'b1);
      cmpFlag(seqErr, 1'b0);
      cmpByte({4'h0, calLanes}, {4'h0, RX_MASK});
      for (i = 0; i < 28; i++)
      begin
         lane = (i < 4) ? 2'h1 : 2'($random(seed));
         code = (i < 4) ? 2'(i) : 2'($random(seed));
         rspDelay = 3'($random(seed));
         access(1'b0, lane, 2'h0, got, err);
         cmpCode(got, expCode[lane]);
         access(1'b1, lane, code, got, err);
         cmpCode(got, 2'h3);
         cmpFlag(err, code == 2'h3);
         if (code != 2'h3) expCode[lane] = code;
         cmpByte(trc_lane_model_inst.txRatio[lane], ratioOf(expCode[lane]));
      end
      for (i = 0; i < 4; i++)
         cmpByte(trc_lane_model_inst.cdrDiv[i], 8'h30 + 8'(i));
      cmpFlag(calDone, 1'b1);
      end_of_test;
   end
endmodule
`default_nettype wire
